// *** rtl/imc_bus_mon.sv ***
// line synchroniser and start/stop condition detector
`timescale 1ns/1ns
module imc_bus_mon import imc_pkg::*; (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // raw lines
  input wire logic scl_i,
  input wire logic sda_i,
  // synchronised lines and events
  output logic scl_s,
  output logic sda_s,
  output logic start_det,
  output logic stop_det
);
  logic scl_m_r;
  logic sda_m_r;
  logic scl_s_r;
  logic sda_s_r;
  logic scl_p_r;
  logic sda_p_r;
  logic start_r;
  logic stop_r;

  // two flops per line, then one more for edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m_r <= 1'b1;
      sda_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      sda_m_r <= sda_i;
      scl_s_r <= scl_m_r;
      sda_s_r <= sda_m_r;
      scl_p_r <= scl_s_r;
      sda_p_r <= sda_s_r;
    end
  end

  // sda edge while scl stays high marks a condition
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      start_r <= scl_s_r && scl_p_r && sda_p_r && !sda_s_r;
      stop_r <= scl_s_r && scl_p_r && !sda_p_r && sda_s_r;
    end
  end

  assign scl_s = scl_s_r;
  assign sda_s = sda_s_r;
  assign start_det = start_r;
  assign stop_det = stop_r;
endmodule

// *** rtl/imc_i2c_mm.sv ***
// two-wire multi-master engine with collision recovery
//
// Overview of operation
// - released one loses to another master's zero
// - sample sda with scl high, flag mismatch
// - collision sets flag, engine returns idle
// - collision halts byte, clears full, releases
// - collision aborts condition, clears all requests
// - stop seen after collision sets event flag
// - new data write restarts at first bit
// - start and stop detection raise interrupts
// - start and stop bits cleared when disabled
// - arbitration checked in address, data, conditions
`timescale 1ns/1ns
module imc_i2c_mm import imc_pkg::*; (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // two-wire pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // interrupt
  output logic irq
);
  // ****************************************
  // declarations
  // ****************************************
  logic aw_h_r;
  logic [ADDR_W-1:0] aw_a_r;
  logic w_h_r;
  logic [31:0] w_d_r;
  logic [3:0] w_s_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic wr_go;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_data;
  logic wr_clr;
  logic [31:0] rd_val;
  logic rd_ok;
  logic en_r;
  logic ackd_r;
  logic [3:0] req_r;
  logic [3:0] req_clr;
  logic [7:0] tx_r;
  logic bf_r;
  logic s_r;
  logic p_r;
  logic ack_rx_r;
  logic [3:0] istat_r;
  logic [3:0] ien_r;
  logic [DIV_W-1:0] div_r;
  imc_state_type state_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [7:0] shreg_r;
  logic sda_low_r;
  logic scl_low_r;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic tick;
  logic [1:0] samp_q;
  logic coll;
  logic done;

  // ****************************************
  // helpers
  // ****************************************
  imc_bus_mon u_mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // divider runs only while a sequence is active
  imc_tick_div u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(state_r != ST_IDLE),
    .div_val(div_r),
    .tick(tick)
  );

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign s_axi_awready = !aw_h_r && !bvalid_r;
  assign s_axi_wready = !w_h_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_go = aw_h_r && w_h_r && !bvalid_r;

  // byte lanes expanded from the strobes
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{w_s_r[i]}};
  end
  assign wd = w_d_r & wmask;
  assign wr_ok = aw_a_r == OFF_CTRL || aw_a_r == OFF_STAT ||
    aw_a_r == OFF_DATA || aw_a_r == OFF_ISTAT ||
    aw_a_r == OFF_ICLR || aw_a_r == OFF_IEN || aw_a_r == OFF_DIV;
  assign wr_ctrl = wr_go && aw_a_r == OFF_CTRL;
  assign wr_data = wr_go && aw_a_r == OFF_DATA && w_s_r[0];
  assign wr_clr = wr_go && aw_a_r == OFF_ICLR;

  // address and data are taken in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_h_r <= 1'b0;
      aw_a_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_h_r <= 1'b1;
      aw_a_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_h_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_h_r <= 1'b0;
      w_d_r <= '0;
      w_s_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_h_r <= 1'b1;
      w_d_r <= s_axi_wdata;
      w_s_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_h_r <= 1'b0;
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read mux; write-only clear reads as zero
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: begin
        rd_val[CB_EN] = en_r;
        rd_val[CB_REQ +: 4] = req_r;
        rd_val[CB_ACKD] = ackd_r;
      end
      OFF_STAT: begin
        rd_val[SB_S] = s_r;
        rd_val[SB_P] = p_r;
        rd_val[SB_BF] = bf_r;
        rd_val[SB_BUSY] = state_r != ST_IDLE;
        rd_val[SB_ACKRX] = ack_rx_r;
      end
      OFF_DATA: rd_val[7:0] = tx_r;
      OFF_ISTAT: rd_val[3:0] = istat_r;
      OFF_ICLR: rd_val = '0;
      OFF_IEN: rd_val[3:0] = ien_r;
      OFF_DIV: rd_val[DIV_W-1:0] = div_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 1'b0;
      ackd_r <= 1'b0;
      ien_r <= '0;
      div_r <= DIV_RST;
    end else if (wr_go) begin
      if (aw_a_r == OFF_CTRL && w_s_r[0]) begin
        en_r <= wd[CB_EN];
        ackd_r <= wd[CB_ACKD];
      end
      if (aw_a_r == OFF_IEN && w_s_r[0])
        ien_r <= wd[3:0];
      if (aw_a_r == OFF_DIV)
        div_r <= (div_r & ~wmask[DIV_W-1:0]) | wd[DIV_W-1:0];
    end
  end

  always_comb begin
    req_clr = '0;
    if (!en_r || coll)
      req_clr = '1;
    else if (done) begin
      req_clr[RQ_START] = state_r == ST_START;
      req_clr[RQ_RSTART] = state_r == ST_RSTART;
      req_clr[RQ_STOP] = state_r == ST_STOP;
      req_clr[RQ_ACK] = state_r == ST_ACK;
    end
  end

  // a software set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      req_r <= '0;
    else if (wr_ctrl)
      req_r <= (req_r & ~req_clr) | wd[CB_REQ +: 4];
    else
      req_r <= req_r & ~req_clr;
  end

  // full flag cleared on collision, write accepted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bf_r <= 1'b0;
      tx_r <= '0;
    end else if (wr_data && !bf_r) begin
      bf_r <= 1'b1;
      tx_r <= wd[7:0];
    end else if (coll || !en_r || (done && state_r == ST_TX)) begin
      bf_r <= 1'b0;
    end
  end

  // condition bits cleared by reset or disable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= 1'b0;
      p_r <= 1'b0;
    end else if (!en_r) begin
      s_r <= 1'b0;
      p_r <= 1'b0;
    end else if (start_det) begin
      s_r <= 1'b1;
      p_r <= 1'b0;
    end else if (stop_det) begin
      s_r <= 1'b0;
      p_r <= 1'b1;
    end
  end

  // sticky until cleared; start and stop events
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      istat_r <= '0;
    else begin
      istat_r <= (istat_r & ~(wr_clr ? wd[3:0] : 4'h0)) |
        {stop_det && en_r, start_det && en_r, coll,
         done || (stop_det && en_r)};
    end
  end

  assign irq = |(istat_r & ien_r);

  // ****************************************
  // bit engine
  // ****************************************
  // sample point per sequence, with scl released
  always_comb begin
    case (state_r)
      ST_START: samp_q = Q1;
      ST_STOP: samp_q = Q3;
      default: samp_q = Q2;
    endcase
  end

  // expected one read back as zero
  assign coll = tick && state_r != ST_IDLE && q_r == samp_q &&
    !(state_r == ST_TX && bit_r == ACK_BIT) &&
    !sda_low_r && scl_s && !sda_s;
  assign done = tick && q_r == Q3 && !coll &&
    state_r != ST_IDLE && (state_r != ST_TX || bit_r == ACK_BIT);

  // collision forces idle; lines let go
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      q_r <= Q0;
      bit_r <= '0;
      shreg_r <= '0;
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
      ack_rx_r <= 1'b0;
    end else if (!en_r || coll) begin
      state_r <= ST_IDLE;
      q_r <= Q0;
      bit_r <= '0;
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      q_r <= Q0;
      bit_r <= '0;
      if (req_r[RQ_START])
        state_r <= ST_START;
      else if (req_r[RQ_RSTART])
        state_r <= ST_RSTART;
      else if (req_r[RQ_STOP])
        state_r <= ST_STOP;
      else if (req_r[RQ_ACK])
        state_r <= ST_ACK;
      else if (bf_r) begin
        // each byte starts at its first bit
        state_r <= ST_TX;
        shreg_r <= tx_r;
      end
    end else if (tick) begin
      q_r <= q_r + 2'h1;
      case (state_r)
        ST_START: begin
          if (q_r == Q0) begin
            sda_low_r <= 1'b0;
            scl_low_r <= 1'b0;
          end
          if (q_r == Q1)
            sda_low_r <= 1'b1;
          if (q_r == Q3)
            scl_low_r <= 1'b1;
        end
        ST_RSTART: begin
          if (q_r == Q0)
            sda_low_r <= 1'b0;
          if (q_r == Q1)
            scl_low_r <= 1'b0;
          if (q_r == Q2)
            sda_low_r <= 1'b1;
          if (q_r == Q3)
            scl_low_r <= 1'b1;
        end
        ST_STOP: begin
          if (q_r == Q0)
            sda_low_r <= 1'b1;
          if (q_r == Q1)
            scl_low_r <= 1'b0;
          if (q_r == Q2)
            sda_low_r <= 1'b0;
        end
        ST_ACK: begin
          if (q_r == Q0)
            sda_low_r <= !ackd_r;
          if (q_r == Q1)
            scl_low_r <= 1'b0;
          if (q_r == Q3)
            scl_low_r <= 1'b1;
        end
        default: begin
          if (q_r == Q0)
            sda_low_r <= bit_r != ACK_BIT && !shreg_r[7];
          if (q_r == Q1)
            scl_low_r <= 1'b0;
          if (q_r == Q2 && bit_r == ACK_BIT)
            ack_rx_r <= sda_s;
          if (q_r == Q3) begin
            scl_low_r <= 1'b1;
            shreg_r <= {shreg_r[6:0], 1'b0};
            bit_r <= bit_r + 4'h1;
          end
        end
      endcase
      if (done)
        state_r <= ST_IDLE;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  coll_sample_a: assert property (coll |-> scl_s && !sda_s &&
    !sda_oe && !scl_oe)
    else $error("collision without released high sda");
  coll_idle_a: assert property (coll |=> state_r == ST_IDLE ##1
    istat_r[IB_COLL] || $past(wr_clr))
    else $error("collision did not reach idle with flag");
  coll_release_a: assert property (coll |=> !sda_oe && !scl_oe &&
    (!bf_r || $past(wr_data)))
    else $error("lines or full flag held after collision");
  coll_req_a: assert property (coll && !wr_ctrl |=> req_r == '0)
    else $error("requests left after collision");
  stop_evt_a: assert property (stop_det && en_r |=>
    istat_r[IB_EVT] && istat_r[IB_STOP])
    else $error("stop did not raise event");
  tx_first_a: assert property ($rose(state_r == ST_TX) |->
    bit_r == '0 && shreg_r == tx_r)
    else $error("byte did not start at first bit");
  start_seen_a: assert property (start_det && en_r |=> s_r && !p_r ##0
    istat_r[IB_START])
    else $error("start not flagged");
  off_clear_a: assert property (!en_r |=> !s_r && !p_r)
    else $error("condition bits kept while disabled");
  coll_where_a: assert property (coll |-> state_r != ST_IDLE && q_r ==
    samp_q)
    else $error("collision outside a sample point");
  coll_sticky_a: assert property (istat_r[IB_COLL] &&
    !(wr_clr && wd[IB_COLL]) |=> istat_r[IB_COLL])
    else $error("collision flag dropped without clear");

  tx_coll_c: cover property (coll && state_r == ST_TX);
  start_coll_c: cover property (coll && state_r == ST_START);
  byte_done_c: cover property (done && state_r == ST_TX);
  stop_after_c: cover property (istat_r[IB_COLL] && stop_det);
endmodule

// *** rtl/imc_pkg.sv ***
// constants and types shared by the multi-master collision block
package imc_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ICLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IEN = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DIV = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register fields
  localparam int CB_EN = 0;
  localparam int CB_REQ = 1;
  localparam int CB_ACKD = 5;
  // condition request indices
  localparam int RQ_START = 0;
  localparam int RQ_RSTART = 1;
  localparam int RQ_STOP = 2;
  localparam int RQ_ACK = 3;
  // status register fields
  localparam int SB_S = 0;
  localparam int SB_P = 1;
  localparam int SB_BF = 2;
  localparam int SB_BUSY = 3;
  localparam int SB_ACKRX = 4;
  // interrupt bits
  localparam int IB_EVT = 0;
  localparam int IB_COLL = 1;
  localparam int IB_START = 2;
  localparam int IB_STOP = 3;
  // ****************************************
  // timing
  // ****************************************
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0138;
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // ****************************************
  // engine states
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_RSTART = 6'h04,
    ST_STOP = 6'h08,
    ST_ACK = 6'h10,
    ST_TX = 6'h20
  } imc_state_type;
endpackage

// *** rtl/imc_tick_div.sv ***
// quarter-bit enable pulse divider
`timescale 1ns/1ns
module imc_tick_div import imc_pkg::*; (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] div_val,
  // enable pulse
  output logic tick
);
  logic [DIV_W-1:0] cnt_r;
  logic tick_r;

  // reload on zero; held in reload while stopped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= DIV_RST;
      tick_r <= 1'b0;
    end else if (!run || cnt_r == '0) begin
      cnt_r <= div_val;
      tick_r <= run;
    end else begin
      cnt_r <= cnt_r - 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule

// *** testbench/i2c_multimaster_collision_test.sv ***
// self-checking bench for the multi-master collision engine
`timescale 1ns/1ns
module i2c_multimaster_collision_test import imc_pkg::*;;
  logic clk, sys_rst, irq, cap_on;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic scl_oe, sda_oe, p_scl_oe, p_sda_oe, scl_o_b, sda_o_b;
  logic [8:0] cap;
  logic [33:0] q_exp[$], q_msk[$], m_res, m_msk;
  logic [31:0] cond [4] = '{32'h3, 32'h5, 32'h9, 32'h31};
  int n_mismatch, samples_checked, n_bits, k;
  // wired-and lines with pull-ups; an enabled driver shows its level
  wire scl_w = (scl_oe ? scl_o_b : 1'b1) && !p_scl_oe;
  wire sda_w = (sda_oe ? sda_o_b : 1'b1) && !p_sda_oe;

  imc_i2c_mm uut (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .scl_i(scl_w), .scl_o(scl_o_b), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o_b), .sda_oe(sda_oe), .irq(irq)
  );
  imc_far_end far (.scl_oe(p_scl_oe), .sda_oe(p_sda_oe));

  // ****************************************
  // clock, helpers, bus tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ready sampled mid-cycle so the release edge is never raced
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    q_exp.push_back({r, 32'h0});
    q_msk.push_back({2'h3, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] r = RESP_OKAY);
    logic ar_t, r_t;
    @(posedge clk);
    q_exp.push_back({r, e});
    q_msk.push_back({2'h3, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask

  // bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 2000 && irq !== lvl; i++) @(negedge clk);
    check(irq, lvl);
  endtask

  // result watcher: each response is matched to the oldest note
  always @(negedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      m_res = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      m_msk = q_msk.pop_front();
      check(m_res & m_msk, q_exp.pop_front() & m_msk);
    end
  end

  // bits on the wire, sampled while scl rises
  always @(posedge scl_w) begin
    if (cap_on) begin
      cap = {cap[7:0], sda_w};
      n_bits++;
    end
  end

  // watchdog: far beyond the several hundred cycles the tests need
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, cap_on} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    seed = 32'd7;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h0); // reset clears S and P
    rd(OFF_ISTAT, 32'h0);
    rd(OFF_DIV, 32'h138);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    $display("test reset and map done");
    // short quarter-bit period keeps the run brief
    wr(OFF_DIV, 32'h4);
    wr(OFF_IEN, 32'h2);
    wr(OFF_CTRL, 32'h1);
    far.hold_sda(1'b1);
    wr(OFF_DATA, 32'hFF);
    wait_irq(1'b1); // released one read back as zero
    check({scl_oe, sda_oe}, 2'b00); // both lines let go
    rd(OFF_STAT, 32'h0, 32'hC); // full and busy dropped
    wr(OFF_ICLR, 32'h0);
    rd(OFF_ISTAT, 32'h2, 32'h2); // flag waits for software
    wr(OFF_IEN, 32'h0);
    wait_irq(1'b0); // masked flag is quiet
    wr(OFF_IEN, 32'h8);
    far.hold_sda(1'b0);
    wait_irq(1'b1); // stop still watched after loss
    rd(OFF_ISTAT, 32'hB, 32'hB); // event flag on stop
    wr(OFF_ICLR, 32'hF);
    wait_irq(1'b0); // cleared by software only
    $display("test byte collision done");
    wr(OFF_IEN, 32'h2);
    for (k = 0; k < 4; k++) begin
      far.hold_sda(1'b1);
      wr(OFF_CTRL, cond[k]);
      wait_irq(1'b1); // loss caught in each condition
      rd(OFF_CTRL, 32'h1, 32'h1F); // requests withdrawn
      check({scl_oe, sda_oe}, 2'b00); // lines released
      far.hold_sda(1'b0);
      wr(OFF_ICLR, 32'hF);
    end
    $display("test condition collisions done");
    // software takes the bus only once a stop was seen
    rd(OFF_STAT, 32'h2, 32'h2); // bus free
    wr(OFF_IEN, 32'h1);
    wr(OFF_ICLR, 32'hF);
    n_bits = 0;
    cap_on = 1'b1;
    wr(OFF_CTRL, 32'h3); // fresh start after the loss
    wait_irq(1'b1);
    seed = xs(seed);
    wr(OFF_ICLR, 32'h1);
    wr(OFF_DATA, {24'h0, seed[7:0]});
    wait_irq(1'b1);
    cap_on = 1'b0;
    check(cap, {seed[7:0], 1'b1}); // all eight bits then ack
    check(n_bits, 9); // no leftover bit position
    wr(OFF_ICLR, 32'h1);
    wr(OFF_CTRL, 32'h9);
    wait_irq(1'b1);
    rd(OFF_STAT, 32'h12, 32'h16); // own stop seen, nack kept
    $display("test restart done");
    wr(OFF_ICLR, 32'hF);
    wr(OFF_IEN, 32'hC);
    far.frame(seed[15:8]);
    rd(OFF_ISTAT, 32'hC, 32'hC); // rival start and stop
    check(irq, 1'b1); // interrupt raised
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STAT, 32'h0, 32'h3); // disable clears S and P
    $display("test rival frame done");
    report_and_stop();
  end
endmodule

// *** testbench/imc_far_end.sv ***
// far-side party: a rival master that can hold or clock the lines
`timescale 1ns/1ns
module imc_far_end (
  // pull-down enables, high while this party drives a line low
  scl_oe,
  sda_oe
);
  output logic scl_oe;
  output logic sda_oe;
  localparam int HALF = 80; // half of the 160 ns link clock

  // lines released at power-up, so the pull-ups win
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // a driven zero beats a released one
  task automatic hold_sda(input logic on);
    sda_oe <= on;
  endtask

  // start, eight clocked bits, then stop
  // non-blocking so that edges landing on a clock edge never race
  task automatic frame(input logic [7:0] b);
    int i;
    sda_oe <= 1'b1;
    #HALF scl_oe <= 1'b1;
    for (i = 7; i >= 0; i--) begin
      sda_oe <= !b[i];
      #HALF scl_oe <= 1'b0;
      #HALF scl_oe <= 1'b1;
    end
    sda_oe <= 1'b1;
    #HALF scl_oe <= 1'b0;
    #HALF sda_oe <= 1'b0; // sda rises with scl high
    #HALF;
  endtask
endmodule
